// [hdl/dccpc_config_regs.svh]
// Register offsets, field positions and reset values of the clock and power configuration bank
`ifndef DCCPC_CONFIG_REGS_SVH
`define DCCPC_CONFIG_REGS_SVH

`define DCCPC_AW              12
`define DCCPC_DW              8

`define DCCPC_ADDR_SYNC       12'h084
`define DCCPC_ADDR_TRIM       12'h085
`define DCCPC_ADDR_SWING      12'h08D
`define DCCPC_ADDR_DRV        12'h08F
`define DCCPC_ADDR_CONV       12'h090
`define DCCPC_ADDR_ACLK       12'h091
`define DCCPC_ADDR_PLL        12'h094

`define DCCPC_SYNC_COUPLE_BIT 6
`define DCCPC_SYNC_PD_BIT     0
`define DCCPC_TRIM_HIGH_MSB   6
`define DCCPC_TRIM_HIGH_LSB   4
`define DCCPC_TRIM_ONE_BIT    1
`define DCCPC_TRIM_ZERO_BIT   0
`define DCCPC_SWING_MSB       4
`define DCCPC_DRV_PD_BIT      0
`define DCCPC_CONV_MSB        1
`define DCCPC_ACLK_PD_BIT     0
`define DCCPC_PLL_DIV3_BIT    1
`define DCCPC_PLL_DIV2_BIT    0

`define DCCPC_RST_BIT_LOW     1'h0
`define DCCPC_RST_BIT_HIGH    1'h1
`define DCCPC_RST_TRIM_HIGH   3'h1
`define DCCPC_RST_SWING       5'h00
`define DCCPC_RST_CONV        2'h3
`define DCCPC_RD_IDLE         8'h00

`define DCCPC_SWING_NEG_FIRST 5'h0A
`define DCCPC_SWING_LAST      5'h13

`endif

// [hdl/dccpc_pkg.sv]
// Types shared by the clock and power configuration bank
package dccpc_pkg;

  typedef enum logic [2:0] {
    REG_NONE, REG_SYNC, REG_TRIM, REG_SWING, REG_DRV, REG_CONV, REG_ACLK, REG_PLL
  } dccpc_reg_t;

  typedef struct packed {
    logic       syncRefCouplingSelect;
    logic       syncRefReceiverPowerDown;
    logic [2:0] trimStartFieldHigh;
    logic       trimStartBitOne;
    logic       trimStartBitZero;
    logic [4:0] obsClockSwingCode;
    logic       obsClockDriverPowerDown;
    logic [1:0] converterPowerDown;
    logic       analogClockRxOff;
    logic       pllDivideByThreeEnable;
    logic       pllDivideByTwoEnable;
  } dccpc_ctrl_t;

  typedef struct packed {
    logic obsClockInverted;
    logic swingCodeInRange;
    logic trimSequenceDone;
    logic pllDivideConflict;
  } dccpc_stat_t;

endpackage : dccpc_pkg

// [hdl/dccpc_config_regs.sv]
// Clock and power configuration register bank of the dual converter
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "dccpc_config_regs.svh"

// Function
// - Sync-reference bit 6 selects AC (0) or DC (1) coupling, read/write.
// - Sync-reference bit 0 resets to 0; writing 1 powers the receiver down.
// - Five-bit swing code resets to 0; codes 10 to 19 invert the clock.
// - Driver control bit 0 resets to 0; 1 powers the clock driver down.
// - Converter bit 1 powers the second converter down; resets to 1.
// - Converter bit 0 powers the first converter down; resets to 1.
// - Analog clock receiver power-down bit resets to 1.
// - PLL divider bit 1 resets to 0; 1 enables divide by three.
// - PLL divider bit 0 resets to 0; 1 halves the converter clock.
module dccpc_config_regs (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Register port
  input  wire logic [`DCCPC_AW-1:0]  regAddr,
  input  wire logic [`DCCPC_DW-1:0]  regWrData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic      [`DCCPC_DW-1:0]  regRdData,
  // Controls to the analog circuits
  output dccpc_pkg::dccpc_ctrl_t     ctrl,
  // Derived status
  output dccpc_pkg::dccpc_stat_t     stat
);

  function automatic dccpc_pkg::dccpc_reg_t decodeAddr(input logic [`DCCPC_AW-1:0] a);
    case (a)
      `DCCPC_ADDR_SYNC:  decodeAddr = dccpc_pkg::REG_SYNC;
      `DCCPC_ADDR_TRIM:  decodeAddr = dccpc_pkg::REG_TRIM;
      `DCCPC_ADDR_SWING: decodeAddr = dccpc_pkg::REG_SWING;
      `DCCPC_ADDR_DRV:   decodeAddr = dccpc_pkg::REG_DRV;
      `DCCPC_ADDR_CONV:  decodeAddr = dccpc_pkg::REG_CONV;
      `DCCPC_ADDR_ACLK:  decodeAddr = dccpc_pkg::REG_ACLK;
      `DCCPC_ADDR_PLL:   decodeAddr = dccpc_pkg::REG_PLL;
      default:           decodeAddr = dccpc_pkg::REG_NONE;
    endcase
  endfunction : decodeAddr

  // Negative swing range inverts the observation clock
  function automatic logic swingNegative(input logic [4:0] code);
    swingNegative = (code >= `DCCPC_SWING_NEG_FIRST) && (code <= `DCCPC_SWING_LAST);
  endfunction : swingNegative

  dccpc_pkg::dccpc_reg_t   wrSel;
  dccpc_pkg::dccpc_reg_t   rdSel;
  logic [`DCCPC_DW-1:0]    readMux;

  logic                    syncCouple_q;
  logic                    syncPd_q;
  logic [2:0]              trimHigh_q;
  logic                    trimOne_q;
  logic                    trimZero_q;
  logic [4:0]              swing_q;
  logic                    drvPd_q;
  logic [1:0]              convPd_q;
  logic                    aclkPd_q;
  logic                    div3_q;
  logic                    div2_q;
  logic                    invert_q;
  logic                    inRange_q;
  logic                    trimDone_q;
  logic                    divConflict_q;
  logic [`DCCPC_DW-1:0]    rdData_q;

  assign wrSel = regWrite ? decodeAddr(regAddr) : dccpc_pkg::REG_NONE;
  assign rdSel = decodeAddr(regAddr);

  // Sync-reference receiver
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncCouple_q <= `DCCPC_RST_BIT_LOW;
      syncPd_q     <= `DCCPC_RST_BIT_LOW;
    end else if (wrSel == dccpc_pkg::REG_SYNC) begin
      syncCouple_q <= regWrData[`DCCPC_SYNC_COUPLE_BIT];
      syncPd_q     <= regWrData[`DCCPC_SYNC_PD_BIT];
    end
  end

  // Start-up trim sequencing; software drives the order, hardware only stores
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trimHigh_q <= `DCCPC_RST_TRIM_HIGH;
      trimOne_q  <= `DCCPC_RST_BIT_HIGH;
      trimZero_q <= `DCCPC_RST_BIT_HIGH;
    end else if (wrSel == dccpc_pkg::REG_TRIM) begin
      trimHigh_q <= regWrData[`DCCPC_TRIM_HIGH_MSB:`DCCPC_TRIM_HIGH_LSB];
      trimOne_q  <= regWrData[`DCCPC_TRIM_ONE_BIT];
      trimZero_q <= regWrData[`DCCPC_TRIM_ZERO_BIT];
    end
  end

  // Observation clock swing and its derived flags, updated together
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swing_q   <= `DCCPC_RST_SWING;
      invert_q  <= `DCCPC_RST_BIT_LOW;
      inRange_q <= `DCCPC_RST_BIT_HIGH;
    end else if (wrSel == dccpc_pkg::REG_SWING) begin
      swing_q   <= regWrData[`DCCPC_SWING_MSB:0];
      invert_q  <= swingNegative(regWrData[`DCCPC_SWING_MSB:0]);
      inRange_q <= regWrData[`DCCPC_SWING_MSB:0] <= `DCCPC_SWING_LAST;
    end
  end

  // Observation clock driver
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drvPd_q <= `DCCPC_RST_BIT_LOW;
    end else if (wrSel == dccpc_pkg::REG_DRV) begin
      drvPd_q <= regWrData[`DCCPC_DRV_PD_BIT];
    end
  end

  // Converter power-down, one bit per converter; both start off
  generate
    for (genvar i = 0; i <= `DCCPC_CONV_MSB; i++) begin : gConv
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          convPd_q[i] <= `DCCPC_RST_BIT_HIGH;
        end else if (wrSel == dccpc_pkg::REG_CONV) begin
          convPd_q[i] <= regWrData[i];
        end
      end
    end
  endgenerate

  // Analog clock receiver
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aclkPd_q <= `DCCPC_RST_BIT_HIGH;
    end else if (wrSel == dccpc_pkg::REG_ACLK) begin
      aclkPd_q <= regWrData[`DCCPC_ACLK_PD_BIT];
    end
  end

  // PLL output divider; both selects set at once is flagged, not blocked
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div3_q        <= `DCCPC_RST_BIT_LOW;
      div2_q        <= `DCCPC_RST_BIT_LOW;
      divConflict_q <= `DCCPC_RST_BIT_LOW;
    end else if (wrSel == dccpc_pkg::REG_PLL) begin
      div3_q        <= regWrData[`DCCPC_PLL_DIV3_BIT];
      div2_q        <= regWrData[`DCCPC_PLL_DIV2_BIT];
      divConflict_q <= regWrData[`DCCPC_PLL_DIV3_BIT] & regWrData[`DCCPC_PLL_DIV2_BIT];
    end
  end

  // Trim sequence complete once all fields hold their run values
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trimDone_q <= `DCCPC_RST_BIT_LOW;
    end else if (wrSel == dccpc_pkg::REG_TRIM) begin
      trimDone_q <= (regWrData[`DCCPC_TRIM_HIGH_MSB:`DCCPC_TRIM_HIGH_LSB] == 3'h0)
                    & ~regWrData[`DCCPC_TRIM_ONE_BIT]
                    & regWrData[`DCCPC_TRIM_ZERO_BIT];
    end
  end

  // Read mux; reserved positions are never stored, so they read zero
  always_comb begin
    readMux = `DCCPC_RD_IDLE;
    case (rdSel)
      dccpc_pkg::REG_SYNC: begin
        readMux[`DCCPC_SYNC_COUPLE_BIT] = syncCouple_q;
        readMux[`DCCPC_SYNC_PD_BIT]     = syncPd_q;
      end
      dccpc_pkg::REG_TRIM: begin
        readMux[`DCCPC_TRIM_HIGH_MSB:`DCCPC_TRIM_HIGH_LSB] = trimHigh_q;
        readMux[`DCCPC_TRIM_ONE_BIT]  = trimOne_q;
        readMux[`DCCPC_TRIM_ZERO_BIT] = trimZero_q;
      end
      dccpc_pkg::REG_SWING: readMux[`DCCPC_SWING_MSB:0]    = swing_q;
      dccpc_pkg::REG_DRV:   readMux[`DCCPC_DRV_PD_BIT]     = drvPd_q;
      dccpc_pkg::REG_CONV:  readMux[`DCCPC_CONV_MSB:0]     = convPd_q;
      dccpc_pkg::REG_ACLK:  readMux[`DCCPC_ACLK_PD_BIT]    = aclkPd_q;
      dccpc_pkg::REG_PLL: begin
        readMux[`DCCPC_PLL_DIV3_BIT] = div3_q;
        readMux[`DCCPC_PLL_DIV2_BIT] = div2_q;
      end
      default: readMux = `DCCPC_RD_IDLE;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_q <= `DCCPC_RD_IDLE;
    end else begin
      rdData_q <= regRead ? readMux : `DCCPC_RD_IDLE;
    end
  end

  assign regRdData = rdData_q;

  assign ctrl.syncRefCouplingSelect    = syncCouple_q;
  assign ctrl.syncRefReceiverPowerDown = syncPd_q;
  assign ctrl.trimStartFieldHigh       = trimHigh_q;
  assign ctrl.trimStartBitOne          = trimOne_q;
  assign ctrl.trimStartBitZero         = trimZero_q;
  assign ctrl.obsClockSwingCode        = swing_q;
  assign ctrl.obsClockDriverPowerDown  = drvPd_q;
  assign ctrl.converterPowerDown       = convPd_q;
  assign ctrl.analogClockRxOff         = aclkPd_q;
  assign ctrl.pllDivideByThreeEnable   = div3_q;
  assign ctrl.pllDivideByTwoEnable     = div2_q;

  assign stat.obsClockInverted  = invert_q;
  assign stat.swingCodeInRange  = inRange_q;
  assign stat.trimSequenceDone  = trimDone_q;
  assign stat.pllDivideConflict = divConflict_q;

  sync_write_a: assert property (@(posedge clock) disable iff (rst)
    regWrite && regAddr == `DCCPC_ADDR_SYNC |=>
      syncCouple_q == $past(regWrData[6]) && syncPd_q == $past(regWrData[0]))
    else $error("sync-reference bits not stored");

  trim_write_a: assert property (@(posedge clock) disable iff (rst)
    regWrite && regAddr == `DCCPC_ADDR_TRIM |=>
      {trimHigh_q, trimOne_q, trimZero_q} == {$past(regWrData[6:4]), $past(regWrData[1:0])})
    else $error("trim fields not stored");

  swing_invert_a: assert property (@(posedge clock) disable iff (rst)
    invert_q == (swing_q >= `DCCPC_SWING_NEG_FIRST && swing_q <= `DCCPC_SWING_LAST))
    else $error("clock inversion disagrees with swing code");

  drv_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_DRV |=> regRdData == {7'h00, drvPd_q})
    else $error("driver register read wrong");

  conv_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_CONV |=>
      regRdData == {6'h00, $past(convPd_q)})
    else $error("converter power-down read wrong");

  aclk_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(regWrite && regAddr == `DCCPC_ADDR_ACLK) |=> $stable(aclkPd_q))
    else $error("analog clock bit changed without a write");

  pll_write_a: assert property (@(posedge clock) disable iff (rst)
    regWrite && regAddr == `DCCPC_ADDR_PLL |=>
      {div3_q, div2_q} == $past(regWrData[1:0]) && divConflict_q == (div3_q & div2_q))
    else $error("divider selects not stored");

  reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_SYNC |=> regRdData[7] == 1'b0 && regRdData[5:1] == 5'h00)
    else $error("reserved bits read nonzero");

  read_idle_a: assert property (@(posedge clock) disable iff (rst)
    !regRead |=> regRdData == 8'h00)
    else $error("read data outside the answer cycle");

  sync_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(regWrite && regAddr == `DCCPC_ADDR_SYNC) |=>
      $stable(syncCouple_q) && $stable(syncPd_q))
    else $error("sync-reference bits changed without a write");

  sync_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_SYNC |=>
      regRdData == {1'h0, $past(syncCouple_q), 5'h00, $past(syncPd_q)})
    else $error("sync-reference register read wrong");

  trim_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(regWrite && regAddr == `DCCPC_ADDR_TRIM) |=>
      $stable({trimHigh_q, trimOne_q, trimZero_q}))
    else $error("trim fields changed without a write");

  trim_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_TRIM |=>
      regRdData == {1'h0, $past(trimHigh_q), 2'h0, $past(trimOne_q), $past(trimZero_q)})
    else $error("trim register read wrong");

  swing_write_a: assert property (@(posedge clock) disable iff (rst)
    regWrite && regAddr == `DCCPC_ADDR_SWING |=>
      swing_q == $past(regWrData[`DCCPC_SWING_MSB:0]))
    else $error("swing code not stored");

  swing_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(regWrite && regAddr == `DCCPC_ADDR_SWING) |=>
      $stable(swing_q))
    else $error("swing code changed without a write");

  swing_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_SWING |=>
      regRdData == {3'h0, $past(swing_q)})
    else $error("swing register read wrong");

  swing_range_a: assert property (@(posedge clock) disable iff (rst)
    inRange_q == (swing_q <= `DCCPC_SWING_LAST))
    else $error("swing range flag disagrees with swing code");

  drv_write_a: assert property (@(posedge clock) disable iff (rst)
    regWrite && regAddr == `DCCPC_ADDR_DRV |=>
      drvPd_q == $past(regWrData[`DCCPC_DRV_PD_BIT]))
    else $error("driver power-down not stored");

  drv_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(regWrite && regAddr == `DCCPC_ADDR_DRV) |=>
      $stable(drvPd_q))
    else $error("driver power-down changed without a write");

  conv_write_a: assert property (@(posedge clock) disable iff (rst)
    regWrite && regAddr == `DCCPC_ADDR_CONV |=>
      convPd_q == $past(regWrData[`DCCPC_CONV_MSB:0]))
    else $error("converter power-down not stored");

  conv_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(regWrite && regAddr == `DCCPC_ADDR_CONV) |=>
      $stable(convPd_q))
    else $error("converter power-down changed without a write");

  aclk_write_a: assert property (@(posedge clock) disable iff (rst)
    regWrite && regAddr == `DCCPC_ADDR_ACLK |=>
      aclkPd_q == $past(regWrData[`DCCPC_ACLK_PD_BIT]))
    else $error("analog clock bit not stored");

  aclk_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_ACLK |=>
      regRdData == {7'h00, $past(aclkPd_q)})
    else $error("analog clock register read wrong");

  pll_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(regWrite && regAddr == `DCCPC_ADDR_PLL) |=>
      $stable({div3_q, div2_q}))
    else $error("divider selects changed without a write");

  pll_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && regAddr == `DCCPC_ADDR_PLL |=>
      regRdData == {6'h00, $past(div3_q), $past(div2_q)})
    else $error("divider register read wrong");

  pll_conflict_a: assert property (@(posedge clock) disable iff (rst)
    divConflict_q == (div3_q && div2_q))
    else $error("divider conflict flag disagrees with selects");

  hole_read_a: assert property (@(posedge clock) disable iff (rst)
    regRead && !(regAddr inside {`DCCPC_ADDR_SYNC, `DCCPC_ADDR_TRIM, `DCCPC_ADDR_SWING,
      `DCCPC_ADDR_DRV, `DCCPC_ADDR_CONV, `DCCPC_ADDR_ACLK, `DCCPC_ADDR_PLL}) |=>
      regRdData == `DCCPC_RD_IDLE)
    else $error("unmapped address read nonzero");

endmodule : dccpc_config_regs

// [verification/dccpc_config_regs_test.sv]
// Self-checking bench for the clock and power configuration bank
`timescale 1ns/1ns
`include "dccpc_config_regs.svh"
module dccpc_config_regs_test;
  logic                   clock;
  logic                   rst;
  logic [`DCCPC_AW-1:0]   regAddr;
  logic [`DCCPC_DW-1:0]   regWrData;
  logic                   regWrite;
  logic                   regRead;
  logic [`DCCPC_DW-1:0]   regRdData;
  dccpc_pkg::dccpc_ctrl_t ctrl;
  dccpc_pkg::dccpc_stat_t stat;
  int                     errTotal;
  int                     totalChecks;

  dccpc_config_regs i_dut (
    .clock     (clock),
    .rst       (rst),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWrite  (regWrite),
    .regRead   (regRead),
    .regRdData (regRdData),
    .ctrl      (ctrl),
    .stat      (stat)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch %s expected 0x%0h seen 0x%0h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  // Data stands one cycle only, then idles at zero
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(what, regRdData, exp);
    @(posedge clock);
    #1 chk({what, " idle"}, regRdData, 8'h00);
  endtask : rd

  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset

  task automatic test_reset_values;
    rd(`DCCPC_ADDR_SYNC, 8'h00, "sync reset");
    rd(`DCCPC_ADDR_TRIM, 8'h13, "trim reset");
    rd(`DCCPC_ADDR_SWING, 8'h00, "swing reset");
    rd(`DCCPC_ADDR_DRV, 8'h00, "driver reset");
    rd(`DCCPC_ADDR_CONV, 8'h03, "converter reset");
    rd(`DCCPC_ADDR_ACLK, 8'h01, "aclk reset");
    rd(`DCCPC_ADDR_PLL, 8'h00, "pll reset");
    chk("reset in range", stat.swingCodeInRange, 8'h01);
    chk("reset inverted", stat.obsClockInverted, 8'h00);
    chk("reset trim done", stat.trimSequenceDone, 8'h00);
    chk("reset conflict", stat.pllDivideConflict, 8'h00);
  endtask : test_reset_values

  task automatic test_sync;
    wr(`DCCPC_ADDR_SYNC, 8'hFF);
    chk("coupling dc", ctrl.syncRefCouplingSelect, 8'h01);
    chk("sync pd on", ctrl.syncRefReceiverPowerDown, 8'h01);
    rd(`DCCPC_ADDR_SYNC, 8'h41, "sync reserved");
    // Subclass 0 setup keeps only the receiver power-down set
    wr(`DCCPC_ADDR_SYNC, 8'h01);
    chk("coupling ac", ctrl.syncRefCouplingSelect, 8'h00);
    rd(`DCCPC_ADDR_SYNC, 8'h01, "sync subclass0");
  endtask : test_sync

  task automatic test_trim;
    wr(`DCCPC_ADDR_TRIM, 8'hFF);
    rd(`DCCPC_ADDR_TRIM, 8'h73, "trim reserved");
    wr(`DCCPC_ADDR_TRIM, 8'h12);
    chk("trim not done", stat.trimSequenceDone, 8'h00);
    wr(`DCCPC_ADDR_TRIM, 8'h01);
    chk("trim field", ctrl.trimStartFieldHigh, 8'h00);
    chk("trim bit one", ctrl.trimStartBitOne, 8'h00);
    chk("trim bit zero", ctrl.trimStartBitZero, 8'h01);
    chk("trim done", stat.trimSequenceDone, 8'h01);
  endtask : test_trim

  // Every code, including the out-of-range ones, with reserved bits set
  task automatic test_swing;
    for (int c = 0; c < 32; c++) begin
      wr(`DCCPC_ADDR_SWING, {3'b111, c[4:0]});
      chk("swing code", ctrl.obsClockSwingCode, {3'b000, c[4:0]});
      chk("swing inverted", stat.obsClockInverted, {7'h00, c >= 10 && c <= 19});
      chk("swing in range", stat.swingCodeInRange, {7'h00, c <= 19});
      rd(`DCCPC_ADDR_SWING, {3'b000, c[4:0]}, "swing read");
    end
  endtask : test_swing

  task automatic test_power;
    wr(`DCCPC_ADDR_DRV, 8'hFF);
    chk("driver pd", ctrl.obsClockDriverPowerDown, 8'h01);
    rd(`DCCPC_ADDR_DRV, 8'h01, "driver read");
    wr(`DCCPC_ADDR_DRV, 8'h00);
    chk("driver on", ctrl.obsClockDriverPowerDown, 8'h00);
    wr(`DCCPC_ADDR_CONV, 8'h02);
    chk("conv second", ctrl.converterPowerDown, 8'h02);
    wr(`DCCPC_ADDR_CONV, 8'hFD);
    chk("conv first", ctrl.converterPowerDown, 8'h01);
    rd(`DCCPC_ADDR_CONV, 8'h01, "conv read");
    wr(`DCCPC_ADDR_ACLK, 8'hFE);
    chk("aclk on", ctrl.analogClockRxOff, 8'h00);
    rd(`DCCPC_ADDR_ACLK, 8'h00, "aclk read");
    wr(`DCCPC_ADDR_ACLK, 8'h01);
    chk("aclk off", ctrl.analogClockRxOff, 8'h01);
    wr(`DCCPC_ADDR_PLL, 8'h02);
    chk("div3 on", ctrl.pllDivideByThreeEnable, 8'h01);
    chk("div2 off", ctrl.pllDivideByTwoEnable, 8'h00);
    wr(`DCCPC_ADDR_PLL, 8'h01);
    chk("div3 off", ctrl.pllDivideByThreeEnable, 8'h00);
    chk("div2 on", ctrl.pllDivideByTwoEnable, 8'h01);
    wr(`DCCPC_ADDR_PLL, 8'hFF);
    chk("pll conflict", stat.pllDivideConflict, 8'h01);
    rd(`DCCPC_ADDR_PLL, 8'h03, "pll read");
  endtask : test_power

  // Holes in the map must neither store nor disturb neighbours
  task automatic test_unmapped;
    wr(12'h08E, 8'hFF);
    wr(12'h092, 8'hFF);
    rd(12'h08E, 8'h00, "hole 08E");
    rd(12'h092, 8'h00, "hole 092");
    rd(`DCCPC_ADDR_DRV, 8'h00, "driver kept");
    chk("aclk kept", ctrl.analogClockRxOff, 8'h01);
  endtask : test_unmapped

  task automatic summarize;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #100000;
    errTotal++;
    summarize();
  end

  initial begin
    errTotal    = 0;
    totalChecks = 0;
    rst         = 1'b1;
    regAddr     = 12'h000;
    regWrData   = 8'h00;
    regWrite    = 1'b0;
    regRead     = 1'b0;
    do_reset();
    test_reset_values();
    test_sync();
    test_trim();
    test_swing();
    test_power();
    test_unmapped();
    // Mid-run reset must restore every default
    do_reset();
    test_reset_values();
    summarize();
  end
endmodule : dccpc_config_regs_test
